// ---- hw/tt_pkg.sv ----
// Package with the constants, field layouts and carrier types of the thermal throttle block.
package tt_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPREQ = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h10;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_AUTO_EN = 0;
  localparam int unsigned CTRL_DUTY_LO = 1;
  localparam int unsigned CTRL_DUTY_HI = 3;
  localparam int unsigned CTRL_OD_EN = 4;
  localparam int unsigned CTRL_OPT_MODE = 5;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int unsigned STS_ACTIVE = 0;
  localparam int unsigned STS_HOT = 1;
  localparam int unsigned STS_SHUT = 2;
  localparam int unsigned STS_ALARM = 3;
  localparam int unsigned STS_OP_LO = 4;
  localparam int unsigned STS_OP_HI = 7;
  localparam int unsigned STS_DEFER = 8;

  // ----------------------------------------------------------------
  // Operating points and clock modulation
  // ----------------------------------------------------------------
  localparam int unsigned OP_W = 4;
  localparam logic [3:0] RST_OPREQ = 4'hf;
  localparam logic [3:0] THERM_OP = 4'h2;
  localparam int unsigned DUTY_W = 3;
  localparam logic [2:0] AUTO_DUTY = 3'h4;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_HOT = 0;
  localparam int unsigned EV_COOL = 1;
  localparam int unsigned EV_TRIP = 2;
  localparam int unsigned EV_OPAPP = 3;
  localparam logic [3:0] RST_IMASK = 4'h0;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tt_wb_req_t;

  typedef struct packed {
    logic ext_irq;
    logic crit;
    logic trip_lo;
    logic trip_hi;
  } tt_sense_t;

  typedef enum logic [2:0] {
    TT_IDLE,
    TT_AUTO_MOD,
    TT_OD_MOD,
    TT_OPT,
    TT_OFF
  } tt_mode_t;

endpackage : tt_pkg

// ---- hw/tt_sync.sv ----
// Two-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/1ps
module tt_sync #(
  parameter int unsigned W = 4
) (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tt_sync_st_t;

  tt_sync_st_t s;
  tt_sync_st_t next_s;

  // The first stage feeds only the second stage, never any logic.
  always_comb
  begin
    next_s.s1 = d_i;
    next_s.s2 = s.s1;
  end

  // Registers, frozen while the clock enable is low.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  assign q_o = s.s2;

endmodule : tt_sync

// ---- hw/tt_duty.sv ----
// Eighths-of-a-period clock modulation pattern generator.
`timescale 1ns/1ps
module tt_duty (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Modulation request and on-time in eighths.
  input wire logic run_i,
  input wire logic [2:0] on_i,
  // High while the core clock may run.
  output logic on_o
);

  typedef struct packed {
    logic [2:0] phase;
  } tt_duty_st_t;

  tt_duty_st_t s;
  tt_duty_st_t next_s;

  // The phase wraps every eight cycles and restarts each time modulation begins.
  always_comb
  begin
    next_s = s;
    next_s.phase = run_i ? s.phase + 3'h1 : 3'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // On for the first on_i phases of each period.
  assign on_o = !run_i || (s.phase < on_i);

endmodule : tt_duty

// ---- hw/tt_ctrl.sv ----
// Thermal throttle controller top: sensing, throttle modes, alarms and register slave.
//
// Operation
// - Hot die with operating-point mode drops the point, then restores the request.
// - Automatic throttling engages only when the die reaches its maximum temperature.
// - Requests above the thermal target wait until the thermal episode ends.
// - Requests below the thermal target are applied at once during an episode.
// - Automatic clock modulation gates the core clock at a fixed half duty.
// - Cooling below the lower threshold stops automatic modulation; the active state clears unless on-demand is enabled.
// - Separate rise and fall thresholds keep the throttle from chattering.
// - The on-demand enable bit starts throttling at once, temperature regardless.
// - On-demand on-time comes from control bits 3:1 in eighths.
// - Automatic throttling overrides on-demand settings when the die is hot.
// - The hot alarm output is low while the die is above the trip point.
// - Snoops are answered the next cycle; interrupts are latched while throttled and served when clock runs.
// - The hot alarm is never newly raised in a clock-stopped low-power state.
// - An alarm raised before low power holds until exit and cooling.
// - A catastrophic temperature shuts the core down in every mode.
// - Shutdown acts independently of core activity and issues no bus cycle.
`timescale 1ns/1ps
module tt_ctrl (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave.
  input wire tt_pkg::tt_wb_req_t wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Asynchronous sensor comparators and external interrupt pin.
  input wire tt_pkg::tt_sense_t sense_i,
  // Core side, same clock.
  input wire logic lp_state_i,
  input wire logic irq_ack_i,
  input wire logic snoop_req_i,
  // Core side outputs.
  output logic core_clk_en_o,
  output logic irq_req_o,
  output logic snoop_ack_o,
  output logic throttle_active_o,
  output logic [3:0] op_point_o,
  // Platform pins.
  output logic hot_alarm_n_o,
  output logic overheat_shutdown_n_o,
  // Software interrupt.
  output logic irq_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic auto_en;
    logic od_en;
    logic opt_mode;
    logic [2:0] od_duty;
    logic [3:0] op_req;
    logic [3:0] op_cur;
    logic deferred;
    logic hot;
    logic alarm;
    logic shut;
    tt_pkg::tt_mode_t mode;
    logic active;
    logic gate;
    logic [3:0] ev;
    logic [3:0] mask;
    logic irq;
    logic irq_pend;
    logic irq_req;
    logic snoop_ack;
  } tt_ctrl_st_t;

  // One registered copy of the whole state; next_s is its combinational image.
  tt_ctrl_st_t s;
  tt_ctrl_st_t next_s;
  // Synchronised sensor levels; only these are read by the logic below.
  tt_pkg::tt_sense_t sn;
  // Modulation request, on-time and the resulting clock-on level.
  logic duty_run;
  logic [2:0] duty_on;
  logic duty_gate;

  // True when a register word holds the given offset.
  function automatic logic is_reg(input logic [7:0] adr, input logic [7:0] ofs);
    is_reg = (adr[7:2] == ofs[7:2]);
  endfunction : is_reg

  // ----------------------------------------------------------------
  // Input synchronisers and modulation pattern
  // ----------------------------------------------------------------
  // The comparators and the interrupt pin are asynchronous, so each passes two flops.
  // This costs two cycles of reaction, far below any thermal time constant.
  tt_sync #(
    .W(4)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(sense_i),
    .q_o(sn)
  );

  // Automatic modulation is pinned at half duty; a zero on-demand field also runs at half.
  always_comb
  begin
    duty_run = (s.mode == tt_pkg::TT_AUTO_MOD) || (s.mode == tt_pkg::TT_OD_MOD);
    duty_on = tt_pkg::AUTO_DUTY;
    if (s.mode == tt_pkg::TT_OD_MOD && s.od_duty != 3'h0)
    begin
      duty_on = s.od_duty;
    end
  end

  tt_duty u_duty (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .run_i(duty_run),
    .on_i(duty_on),
    .on_o(duty_gate)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic hit;
    logic wr;
    logic auto_hot;
    logic [3:0] set_ev;
    logic [3:0] clr_ev;
    // Defaults first, so that every local and every field has a value on every path.
    hit = wb_i.cyc && wb_i.stb && !s.ack;
    wr = hit && wb_i.we && wb_i.sel[0];
    set_ev = 4'h0;
    clr_ev = 4'h0;
    auto_hot = 1'b0;
    next_s = s;
    next_s.ack = hit;

    // Trip detection uses two thresholds so noise near the trip cannot chatter.
    if (sn.trip_hi)
    begin
      next_s.hot = 1'b1;
    end
    else if (!sn.trip_lo)
    begin
      next_s.hot = 1'b0;
    end
    set_ev[tt_pkg::EV_HOT] = next_s.hot && !s.hot;
    set_ev[tt_pkg::EV_COOL] = !next_s.hot && s.hot;

    // Shutdown latches until reset; it needs no core cooperation and no bus cycle.
    if (sn.crit)
    begin
      next_s.shut = 1'b1;
    end
    set_ev[tt_pkg::EV_TRIP] = next_s.shut && !s.shut;

    // Mode selection, shutdown first, then automatic, then on-demand.
    // Shutdown outranks every mode; automatic outranks on-demand only while hot.
    auto_hot = s.auto_en && s.hot;
    if (s.shut)
    begin
      next_s.mode = tt_pkg::TT_OFF;
    end
    else if (auto_hot && s.opt_mode)
    begin
      next_s.mode = tt_pkg::TT_OPT;
    end
    else if (auto_hot)
    begin
      next_s.mode = tt_pkg::TT_AUTO_MOD;
    end
    else if (s.od_en)
    begin
      next_s.mode = tt_pkg::TT_OD_MOD;
    end
    else
    begin
      next_s.mode = tt_pkg::TT_IDLE;
    end
    next_s.active = (next_s.mode != tt_pkg::TT_IDLE);

    // The core clock stops for good once shutdown is taken.
    // The new shutdown value is used so the clock stops in the same cycle as the pin.
    next_s.gate = !next_s.shut && duty_gate;

    // Operating point: higher code means higher frequency.
    // A request at the target simply stays there; only one above it is flagged.
    if (s.mode == tt_pkg::TT_OPT)
    begin
      if (s.op_req < tt_pkg::THERM_OP)
      begin
        next_s.op_cur = s.op_req;
        next_s.deferred = 1'b0;
      end
      else
      begin
        next_s.op_cur = tt_pkg::THERM_OP;
        next_s.deferred = (s.op_req > tt_pkg::THERM_OP);
      end
    end
    else
    begin
      next_s.op_cur = s.op_req;
      next_s.deferred = 1'b0;
      set_ev[tt_pkg::EV_OPAPP] = s.deferred;
    end

    // A low-power state freezes the alarm; it can neither rise nor fall inside it.
    if (!lp_state_i)
    begin
      next_s.alarm = s.hot;
    end
    else
    begin
      next_s.alarm = s.alarm;
    end

    // External interrupts stay latched while throttled and are offered only with clock on.
    if (irq_ack_i)
    begin
      next_s.irq_pend = 1'b0;
    end
    if (sn.ext_irq)
    begin
      next_s.irq_pend = 1'b1;
    end
    next_s.irq_req = next_s.irq_pend && next_s.gate;
    next_s.snoop_ack = snoop_req_i;

    // Register writes.
    // Only byte lane 0 carries fields, so a write without it changes nothing.
    if (wr && is_reg(wb_i.adr, tt_pkg::OFS_CTRL))
    begin
      next_s.auto_en = wb_i.dat[tt_pkg::CTRL_AUTO_EN];
      next_s.od_duty = wb_i.dat[tt_pkg::CTRL_DUTY_HI:tt_pkg::CTRL_DUTY_LO];
      next_s.od_en = wb_i.dat[tt_pkg::CTRL_OD_EN];
      next_s.opt_mode = wb_i.dat[tt_pkg::CTRL_OPT_MODE];
    end
    if (wr && is_reg(wb_i.adr, tt_pkg::OFS_OPREQ))
    begin
      next_s.op_req = wb_i.dat[3:0];
    end
    if (wr && is_reg(wb_i.adr, tt_pkg::OFS_IMASK))
    begin
      next_s.mask = wb_i.dat[3:0];
    end
    if (wr && is_reg(wb_i.adr, tt_pkg::OFS_ISTAT))
    begin
      clr_ev = wb_i.dat[3:0];
    end

    // Write-one-to-clear; an event in the same cycle keeps its bit set.
    next_s.ev = (s.ev & ~clr_ev) | set_ev;
    next_s.irq = |(next_s.ev & next_s.mask);

    // Read data, zero for unmapped words.
    // Zero outside an acknowledged read keeps any bus multiplexer downstream simple.
    next_s.dat = 32'h0000_0000;
    if (hit && !wb_i.we)
    begin
      if (is_reg(wb_i.adr, tt_pkg::OFS_CTRL))
      begin
        next_s.dat[tt_pkg::CTRL_AUTO_EN] = s.auto_en;
        next_s.dat[tt_pkg::CTRL_DUTY_HI:tt_pkg::CTRL_DUTY_LO] = s.od_duty;
        next_s.dat[tt_pkg::CTRL_OD_EN] = s.od_en;
        next_s.dat[tt_pkg::CTRL_OPT_MODE] = s.opt_mode;
      end
      else if (is_reg(wb_i.adr, tt_pkg::OFS_OPREQ))
      begin
        next_s.dat[3:0] = s.op_req;
      end
      else if (is_reg(wb_i.adr, tt_pkg::OFS_STATUS))
      begin
        next_s.dat[tt_pkg::STS_ACTIVE] = s.active;
        next_s.dat[tt_pkg::STS_HOT] = s.hot;
        next_s.dat[tt_pkg::STS_SHUT] = s.shut;
        next_s.dat[tt_pkg::STS_ALARM] = s.alarm;
        next_s.dat[tt_pkg::STS_OP_HI:tt_pkg::STS_OP_LO] = s.op_cur;
        next_s.dat[tt_pkg::STS_DEFER] = s.deferred;
      end
      else if (is_reg(wb_i.adr, tt_pkg::OFS_ISTAT))
      begin
        next_s.dat[3:0] = s.ev;
      end
      else if (is_reg(wb_i.adr, tt_pkg::OFS_IMASK))
      begin
        next_s.dat[3:0] = s.mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset loads the package defaults; a low enable freezes every other update.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s <= '0;
      s.auto_en <= tt_pkg::RST_CTRL[tt_pkg::CTRL_AUTO_EN];
      s.od_en <= tt_pkg::RST_CTRL[tt_pkg::CTRL_OD_EN];
      s.opt_mode <= tt_pkg::RST_CTRL[tt_pkg::CTRL_OPT_MODE];
      s.od_duty <= tt_pkg::RST_CTRL[tt_pkg::CTRL_DUTY_HI:tt_pkg::CTRL_DUTY_LO];
      s.op_req <= tt_pkg::RST_OPREQ;
      s.op_cur <= tt_pkg::RST_OPREQ;
      s.mask <= tt_pkg::RST_IMASK;
      s.mode <= tt_pkg::TT_IDLE;
      s.gate <= 1'b1;
    end
    else if (ce_i)
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign core_clk_en_o = s.gate;
  assign irq_req_o = s.irq_req;
  assign snoop_ack_o = s.snoop_ack;
  assign throttle_active_o = s.active;
  assign op_point_o = s.op_cur;
  // Both platform pins are active low and idle high out of reset.
  assign hot_alarm_n_o = !s.alarm;
  assign overheat_shutdown_n_o = !s.shut;
  assign irq_o = s.irq;

endmodule : tt_ctrl

// ---- sim/tt_ctrl_properties.sv ----
// Concurrent checks on the ports of the thermal throttle controller.
`timescale 1ns/1ps
module tt_ctrl_properties (
  // Clock, reset and enable.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register bus.
  input wire tt_pkg::tt_wb_req_t wb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  // Core side.
  input wire logic lp_state_i,
  input wire logic snoop_req_i,
  input wire logic core_clk_en_o,
  input wire logic irq_req_o,
  input wire logic snoop_ack_o,
  input wire logic throttle_active_o,
  // Platform pins.
  input wire logic hot_alarm_n_o,
  input wire logic overheat_shutdown_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_ack; wb_i.cyc && wb_i.stb && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause; wb_ack_o |-> $past(wb_i.cyc && wb_i.stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  property p_shut_hold; !overheat_shutdown_n_o |=> !overheat_shutdown_n_o; endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown released");
  property p_shut_clk; !overheat_shutdown_n_o |-> !core_clk_en_o; endproperty
  a_shut_clk: assert property (p_shut_clk) else $error("clock runs in shutdown");
  property p_snoop; snoop_req_i |=> snoop_ack_o; endproperty
  a_snoop: assert property (p_snoop) else $error("snoop not answered");
  property p_alarm_lp; lp_state_i |=> $stable(hot_alarm_n_o); endproperty
  a_alarm_lp: assert property (p_alarm_lp) else $error("alarm moved in low power");
  // Looks three cycles back so that a lag of the pattern behind the flag is tolerated.
  property p_idle_clk; !throttle_active_o [*6] |-> $past(core_clk_en_o, 3); endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock gated while idle");
  property p_irq_on; irq_req_o |-> core_clk_en_o; endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt offered, clock off");

  // Main scenarios reached.
  c_shut: cover property (!overheat_shutdown_n_o);
  c_alarm: cover property ($fell(hot_alarm_n_o));
  c_lp_hold: cover property (lp_state_i && !hot_alarm_n_o);
  c_irq: cover property (irq_req_o);
endmodule : tt_ctrl_properties

bind tt_ctrl tt_ctrl_properties i_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .lp_state_i(lp_state_i),
  .snoop_req_i(snoop_req_i), .core_clk_en_o(core_clk_en_o), .irq_req_o(irq_req_o),
  .snoop_ack_o(snoop_ack_o), .throttle_active_o(throttle_active_o),
  .hot_alarm_n_o(hot_alarm_n_o), .overheat_shutdown_n_o(overheat_shutdown_n_o));

// ---- sim/tt_platform_model.sv ----
// Platform model: die temperature comparators and the core supply switch.
`timescale 1ns/1ps
module tt_platform_model #(
  parameter int unsigned HOT_C = 100,
  parameter int unsigned COOL_C = 97,
  parameter int unsigned CRIT_C = 125,
  parameter int unsigned OFF_LIM = 20
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Die temperature and external interrupt level.
  input wire logic [7:0] temp_i,
  input wire logic ext_irq_i,
  // Shutdown pin in, comparators and supply state out.
  input wire logic overheat_shutdown_n_i,
  output tt_pkg::tt_sense_t sense_o,
  output logic vcore_on_o
);
  int unsigned n_off;

  // Two thresholds leave the controller room for hysteresis.
  assign sense_o = '{ext_irq_i, temp_i >= CRIT_C, temp_i >= COOL_C, temp_i >= HOT_C};

  // Supply is cut a bounded time after shutdown is signalled.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || overheat_shutdown_n_i)
      n_off <= 0;
    else if (n_off < OFF_LIM)
      n_off <= n_off + 1;
    vcore_on_o <= rst_i || (n_off < OFF_LIM);
  end
endmodule : tt_platform_model

// ---- sim/tt_ctrl_tb_top.sv ----
// Self-checking bench for the thermal throttle controller.
`timescale 1ns/1ps
module tt_ctrl_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tt_pkg::tt_wb_req_t wb_i = '0;
  logic lp_state_i = 1'b0;
  logic irq_ack_i = 1'b0;
  logic snoop_req_i = 1'b0;
  logic ext_irq = 1'b0;
  logic [7:0] temp = 8'd40;
  logic ce_i = 1'b1;
  tt_pkg::tt_sense_t sense;
  logic wb_ack_o, core_clk_en_o, irq_req_o, snoop_ack_o, throttle_active_o;
  logic hot_alarm_n_o, overheat_shutdown_n_o, irq_o, vcore_on, seen;
  logic [31:0] wb_dat_o, rd;
  logic [3:0] op_point_o;
  int n_fail = 0;
  int num_checks = 0;
  int cyc_n = 0;

  always #50 clk_i = ~clk_i;

  // The enable is driven so that a freeze of the whole block can be checked.
  tt_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sense_i(sense), .lp_state_i(lp_state_i),
    .irq_ack_i(irq_ack_i), .snoop_req_i(snoop_req_i), .core_clk_en_o(core_clk_en_o),
    .irq_req_o(irq_req_o), .snoop_ack_o(snoop_ack_o), .throttle_active_o(throttle_active_o),
    .op_point_o(op_point_o), .hot_alarm_n_o(hot_alarm_n_o),
    .overheat_shutdown_n_o(overheat_shutdown_n_o), .irq_o(irq_o));
  tt_platform_model i_plat (.clk_i(clk_i), .rst_i(rst_i), .temp_i(temp), .ext_irq_i(ext_irq),
    .overheat_shutdown_n_i(overheat_shutdown_n_o), .sense_o(sense), .vcore_on_o(vcore_on));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task print_verdict();
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, s, e);
    end
  endtask : chk

  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // Classic cycle: held until ack is sampled, then released for a cycle.
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_i <= '{1'b1, 1'b1, w, a, 4'hf, d};
    @(posedge clk_i iff wb_ack_o === 1'b1);
    rd = wb_dat_o;
    wb_i <= '0;
  endtask : acc

  task rdc(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc

  // Counts clock-on cycles over two whole modulation periods.
  task ontime(input logic [31:0] e);
    int c;
    c = 0;
    repeat (16)
    begin
      @(posedge clk_i);
      c += (core_clk_en_o === 1'b1);
    end
    chk(c, e);
  endtask : ontime

  // Allows for the synchroniser and the state pipeline behind a change.
  task heat(input logic [7:0] t);
    @(posedge clk_i);
    temp <= t;
    wt(10);
  endtask : heat

  task lp(input logic v);
    @(posedge clk_i);
    lp_state_i <= v;
  endtask : lp

  // A hang is cut short long after the sequence should have ended.
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 8000)
    begin
      n_fail++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    wt(3);
    rst_i <= 1'b0;
    // Reset values, with an unmapped address last.
    rdc(tt_pkg::OFS_CTRL, 32'h0);
    rdc(tt_pkg::OFS_OPREQ, 32'hf);
    rdc(tt_pkg::OFS_ISTAT, 32'h0);
    rdc(tt_pkg::OFS_IMASK, 32'h0);
    rdc(8'h20, 32'h0);
    chk({throttle_active_o, hot_alarm_n_o, op_point_o}, 32'h1f);
    // Every on-demand duty code on a cold die; code 0 runs at half.
    for (int d = 0; d < 8; d++)
    begin
      acc(1'b1, tt_pkg::OFS_CTRL, 32'h10 | (d << 1));
      wt(4);
      chk(throttle_active_o, 1'b1);
      ontime((d == 0) ? 8 : 2 * d);
    end
    acc(1'b1, tt_pkg::OFS_CTRL, 32'h0);
    wt(4);
    chk(throttle_active_o, 1'b0);
    // Automatic mode between the thresholds from cold stays idle.
    acc(1'b1, tt_pkg::OFS_CTRL, 32'h01);
    heat(8'd98);
    chk({throttle_active_o, hot_alarm_n_o}, 32'h1);
    acc(1'b1, tt_pkg::OFS_CTRL, 32'h13);
    wt(4);
    heat(8'd105);
    chk({throttle_active_o, hot_alarm_n_o}, 32'h2);
    ontime(8);
    acc(1'b1, tt_pkg::OFS_IMASK, 32'h1);
    wt(2);
    chk(irq_o, 1'b1);
    rdc(tt_pkg::OFS_ISTAT, 32'h1);
    acc(1'b1, tt_pkg::OFS_ISTAT, 32'h1);
    wt(2);
    chk(irq_o, 1'b0);
    heat(8'd98);
    ontime(8);
    heat(8'd90);
    chk(hot_alarm_n_o, 1'b1);
    ontime(2);
    // Interrupts and snoops still served while throttled.
    @(posedge clk_i);
    ext_irq <= 1'b1;
    seen = 1'b0;
    repeat (16) @(posedge clk_i) seen |= (irq_req_o === 1'b1);
    chk(seen, 1'b1);
    @(posedge clk_i);
    snoop_req_i <= 1'b1;
    ext_irq <= 1'b0;
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    snoop_req_i <= 1'b0;
    @(posedge clk_i);
    chk(snoop_ack_o, 1'b1);
    wt(5);
    irq_ack_i <= 1'b0;
    wt(4);
    chk(irq_req_o, 1'b0);
    acc(1'b1, tt_pkg::OFS_CTRL, 32'h01);
    wt(4);
    chk(throttle_active_o, 1'b0);
    // Operating-point throttling with deferred and direct requests.
    acc(1'b1, tt_pkg::OFS_OPREQ, 32'h9);
    acc(1'b1, tt_pkg::OFS_CTRL, 32'h21);
    wt(4);
    chk(op_point_o, 4'h9);
    heat(8'd105);
    chk(op_point_o, tt_pkg::THERM_OP);
    acc(1'b1, tt_pkg::OFS_OPREQ, 32'hc);
    wt(4);
    chk(op_point_o, tt_pkg::THERM_OP);
    acc(1'b0, tt_pkg::OFS_STATUS, 32'h0);
    chk(rd[tt_pkg::STS_DEFER], 1'b1);
    heat(8'd90);
    chk(op_point_o, 4'hc);
    acc(1'b0, tt_pkg::OFS_ISTAT, 32'h0);
    chk(rd[tt_pkg::EV_OPAPP], 1'b1);
    heat(8'd105);
    acc(1'b1, tt_pkg::OFS_OPREQ, 32'h1);
    wt(4);
    chk(op_point_o, 4'h1);
    heat(8'd90);
    chk(op_point_o, 4'h1);
    // Alarm in the clock-stopped state: no new rise, an old one held.
    lp(1'b1);
    heat(8'd105);
    chk(hot_alarm_n_o, 1'b1);
    lp(1'b0);
    wt(6);
    chk(hot_alarm_n_o, 1'b0);
    lp(1'b1);
    heat(8'd90);
    chk(hot_alarm_n_o, 1'b0);
    lp(1'b0);
    wt(6);
    chk(hot_alarm_n_o, 1'b1);
    // A low enable freezes everything, synchronisers included; heat lands on release.
    @(posedge clk_i);
    ce_i <= 1'b0;
    heat(8'd105);
    chk({hot_alarm_n_o, throttle_active_o}, 32'h2);
    @(posedge clk_i);
    ce_i <= 1'b1;
    wt(6);
    chk({hot_alarm_n_o, throttle_active_o}, 32'h1);
    // Catastrophic heat shuts down, raises its interrupt and stays down.
    acc(1'b1, tt_pkg::OFS_IMASK, 32'h4);
    heat(8'd130);
    chk({overheat_shutdown_n_o, core_clk_en_o, irq_o}, 32'h1);
    heat(8'd40);
    wt(20);
    chk({overheat_shutdown_n_o, vcore_on}, 32'h0);
    print_verdict();
  end
endmodule : tt_ctrl_tb_top
